// >>> rsd_rx_stream_dma.sv
`timescale 1ns/1ps
// Function
// RULE1: filled and release are two bits, one per area.
// RULE2: set filled only after area's last beat.
// RULE3: release pulse clears matching filled bit.
// RULE4: never write an area still filled.
// RULE5: host reads area only when filled set.
// RULE6: packets are 128 words, last may be shorter.
// RULE7: area size is a multiple of 128 words.
// RULE8: sizes come in 64-byte units with start.
// RULE9: accept start only idle; load counters, set busy.
// RULE10: on accept select area 0, go check.
// RULE11: check waits FIFO 128 words and area free.
// RULE12: final loop waits FIFO holding remaining total.
// RULE13: begin state one cycle, subtracts burst size.
// RULE14: leave data state on last beat accepted.
// RULE15: total zero in check gives idle, busy low.
// RULE16: 512x512 fall-through staging FIFO.
// RULE17: pull engine word when nonempty, count below 504.
// RULE18: area last loop toggles selector, sets filled.
// RULE19: ready low stalls reads and holds data.
// RULE20: last with final beat, drop after acceptance.
// RULE21: burst loads 128 or remainder, counts down.
// RULE22: one fixed DMA channel per instance.
// RULE23: reset gives idle, flags low, FIFO empty.
module rsd_rx_stream_dma #(
  parameter logic [rsd_pkg::CH_W-1:0] P_DMA_CHANNEL = 8'h00
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire rsd_pkg::rsd_req_t i_req,
  output logic o_rx_xfer_busy,
  output logic [1:0] o_rx_area_filled,
  input wire logic [1:0] i_rx_area_release,
  input wire logic i_engine_fifo_empty,
  input wire logic [rsd_pkg::DATA_W-1:0] i_engine_data,
  output logic o_engine_rd_en,
  output rsd_pkg::rsd_axis_t o_stream,
  input wire logic i_dma_out_ready,
  output logic [rsd_pkg::CH_W-1:0] o_dma_channel,
  output logic [rsd_pkg::FIFO_CW-1:0] o_stage_fifo_count
);
  import rsd_pkg::*;

  rsd_state_t state_ff, nxt_state;
  logic busy_ff, nxt_busy;
  logic [SIZE_W-1:0] remaining_total_cnt_ff, nxt_remaining_total_cnt;
  logic [SIZE_W-1:0] remaining_area_cnt_ff, nxt_remaining_area_cnt;
  logic [SIZE_W-1:0] area_size_ff, nxt_area_size;
  logic area_selector_ff, nxt_area_selector;
  logic area_last_loop_ff, nxt_area_last_loop;
  logic [BURST_W-1:0] burst_remaining_ff, nxt_burst_remaining;
  logic [1:0] area_filled_ff, nxt_area_filled;
  logic [1:0] area_set;
  logic loop_read_active_ff, nxt_loop_read_active;
  logic [DATA_W-1:0] out_data_ff, nxt_out_data;
  logic out_valid_ff, nxt_out_valid;
  logic out_last_ff, nxt_out_last;
  logic [DATA_W-1:0] staging_fifo [2**FIFO_AW];
  logic [FIFO_AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [FIFO_AW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [FIFO_CW-1:0] stage_fifo_count_ff, nxt_stage_fifo_count;
  logic [DATA_W-1:0] stage_fifo_out;
  logic stage_fifo_read_ack;
  logic engine_pull;
  logic final_loop;
  logic [SIZE_W-1:0] need_words;
  logic area_ready;
  logic beat_done;
  logic loop_end;

  // Pull from the engine only with room left in the staging FIFO.
  assign engine_pull = !i_engine_fifo_empty && (stage_fifo_count_ff < FIFO_PULL_LIMIT); // RULE17
  // Fall-through read: the head word is visible with the acknowledge.
  assign stage_fifo_out = staging_fifo[rd_ptr_ff]; // RULE16
  // A read is made only while the output register can take a word.
  assign stage_fifo_read_ack = loop_read_active_ff && (!out_valid_ff || i_dma_out_ready); // RULE19
  assign beat_done = out_valid_ff && i_dma_out_ready;
  assign loop_end = beat_done && out_last_ff; // RULE14
  // final_loop marks a loop with less than a full packet of the request left.
  assign final_loop = remaining_total_cnt_ff < PKT_WORDS;
  assign need_words = final_loop ? remaining_total_cnt_ff : PKT_WORDS; // RULE11 RULE12
  assign area_ready = !area_filled_ff[area_selector_ff]; // RULE4
  assign area_set = (loop_end && area_last_loop_ff) ? (area_selector_ff ? 2'b10 : 2'b01) : AREA_NONE;

  // Staging FIFO pointer and word count next values.
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_stage_fifo_count = stage_fifo_count_ff;
    if (engine_pull) begin
      nxt_wr_ptr = wr_ptr_ff + PTR_ONE;
    end
    if (stage_fifo_read_ack) begin
      nxt_rd_ptr = rd_ptr_ff + PTR_ONE;
    end
    if (engine_pull && !stage_fifo_read_ack) begin
      nxt_stage_fifo_count = stage_fifo_count_ff + CNT_ONE;
    end else if (!engine_pull && stage_fifo_read_ack) begin
      nxt_stage_fifo_count = stage_fifo_count_ff - CNT_ONE;
    end
  end

  // Staging FIFO state; reset empties it, storage needs no reset.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wr_ptr_ff <= '0; // RULE23
      rd_ptr_ff <= '0;
      stage_fifo_count_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      stage_fifo_count_ff <= nxt_stage_fifo_count;
    end
  end

  // Word storage of the staging FIFO.
  always_ff @(posedge i_ref_clk) begin
    if (engine_pull) begin
      staging_fifo[wr_ptr_ff] <= i_engine_data; // RULE16
    end
  end

  // Sequencer and counter next values.
  always_comb begin
    nxt_state = state_ff;
    nxt_busy = busy_ff;
    nxt_remaining_total_cnt = remaining_total_cnt_ff;
    nxt_remaining_area_cnt = remaining_area_cnt_ff;
    nxt_area_size = area_size_ff;
    nxt_area_selector = area_selector_ff;
    nxt_area_last_loop = area_last_loop_ff;
    nxt_burst_remaining = burst_remaining_ff;
    nxt_loop_read_active = loop_read_active_ff;
    case (state_ff)
      state_idle: begin
        if (i_req.rx_xfer_start) begin // RULE9 RULE8
          nxt_busy = 1'b1;
          nxt_remaining_total_cnt = i_req.rx_total_size;
          nxt_remaining_area_cnt = i_req.rx_area_size;
          nxt_area_size = i_req.rx_area_size;
          nxt_area_selector = 1'b0; // RULE10
          nxt_state = state_check_ready;
        end
      end
      state_check_ready: begin
        // Burst size is 128 words, or the remainder on the final loop.
        nxt_burst_remaining = final_loop ? remaining_total_cnt_ff[BURST_W-1:0] : PKT_WORDS_B; // RULE21 RULE6
        if (remaining_total_cnt_ff == SIZE_ZERO) begin
          nxt_busy = 1'b0; // RULE15
          nxt_state = state_idle;
        end else if (area_ready && ({22'h0, stage_fifo_count_ff} >= need_words)) begin // RULE11 RULE12
          nxt_state = state_begin_loop;
        end
      end
      state_begin_loop: begin
        // One cycle: update counters and start reading the loop.
        nxt_remaining_total_cnt = remaining_total_cnt_ff - {24'h0, burst_remaining_ff}; // RULE13
        nxt_remaining_area_cnt = remaining_area_cnt_ff - {24'h0, burst_remaining_ff};
        nxt_area_last_loop = remaining_area_cnt_ff == {24'h0, burst_remaining_ff}; // RULE18 RULE7
        nxt_loop_read_active = 1'b1;
        nxt_state = state_move_data;
      end
      state_move_data: begin
        if (stage_fifo_read_ack) begin
          nxt_burst_remaining = burst_remaining_ff - BURST_ONE; // RULE21
          if (burst_remaining_ff == BURST_ONE) begin
            nxt_loop_read_active = 1'b0;
          end
        end
        if (loop_end) begin // RULE14
          if (area_last_loop_ff) begin
            nxt_area_selector = !area_selector_ff; // RULE18
            nxt_remaining_area_cnt = area_size_ff;
          end
          nxt_area_last_loop = 1'b0;
          nxt_state = state_check_ready;
        end
      end
      default: begin
        nxt_state = state_idle;
        nxt_busy = 1'b0;
        nxt_loop_read_active = 1'b0;
      end
    endcase
  end

  // Sequencer and counter registers.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_ff <= state_idle; // RULE23
      busy_ff <= 1'b0;
      remaining_total_cnt_ff <= '0;
      remaining_area_cnt_ff <= '0;
      area_size_ff <= '0;
      area_selector_ff <= 1'b0;
      area_last_loop_ff <= 1'b0;
      burst_remaining_ff <= '0;
      loop_read_active_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      remaining_total_cnt_ff <= nxt_remaining_total_cnt;
      remaining_area_cnt_ff <= nxt_remaining_area_cnt;
      area_size_ff <= nxt_area_size;
      area_selector_ff <= nxt_area_selector;
      area_last_loop_ff <= nxt_area_last_loop;
      burst_remaining_ff <= nxt_burst_remaining;
      loop_read_active_ff <= nxt_loop_read_active;
    end
  end

  // Area flags: a set in the same cycle as a release wins.
  always_comb begin
    nxt_area_filled = (area_filled_ff & ~i_rx_area_release) | area_set; // RULE1 RULE2 RULE3
  end

  // Stream output register: loads on each read, holds while stalled.
  always_comb begin
    nxt_out_data = out_data_ff;
    nxt_out_valid = out_valid_ff;
    nxt_out_last = out_last_ff;
    if (stage_fifo_read_ack) begin
      nxt_out_data = stage_fifo_out;
      nxt_out_valid = 1'b1;
      nxt_out_last = burst_remaining_ff == BURST_ONE; // RULE20
    end else if (beat_done) begin
      nxt_out_valid = 1'b0; // RULE20
      nxt_out_last = 1'b0;
    end
  end

  // Output and flag registers.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      area_filled_ff <= AREA_NONE; // RULE23
      out_data_ff <= '0;
      out_valid_ff <= 1'b0;
      out_last_ff <= 1'b0;
    end else begin
      area_filled_ff <= nxt_area_filled;
      out_data_ff <= nxt_out_data; // RULE19
      out_valid_ff <= nxt_out_valid;
      out_last_ff <= nxt_out_last;
    end
  end

  // Output assignments.
  assign o_rx_xfer_busy = busy_ff;
  assign o_rx_area_filled = area_filled_ff;
  assign o_engine_rd_en = engine_pull;
  assign o_stream.dma_out_data = out_data_ff;
  assign o_stream.dma_out_valid = out_valid_ff;
  assign o_stream.dma_out_last = out_last_ff;
  assign o_dma_channel = P_DMA_CHANNEL; // RULE22
  assign o_stage_fifo_count = stage_fifo_count_ff;

  // Checks on the sequencer, stream and flags.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  chk_start_accept: assert property ( // RULE9
    state_ff == state_idle && i_req.rx_xfer_start |=> busy_ff && state_ff == state_check_ready
      && remaining_total_cnt_ff == $past(i_req.rx_total_size) && !area_selector_ff)
    else $error("Start not accepted as expected.");

  chk_begin_one: assert property ( // RULE13
    state_ff == state_begin_loop |=> state_ff == state_move_data
      && remaining_total_cnt_ff == $past(remaining_total_cnt_ff) - {24'h0, $past(burst_remaining_ff)})
    else $error("Begin state did not subtract the burst.");

  chk_pull_gate: assert property ( // RULE17
    o_engine_rd_en |-> !i_engine_fifo_empty && stage_fifo_count_ff < FIFO_PULL_LIMIT)
    else $error("Engine pulled without room.");

  chk_fifo_bound: assert property ( // RULE17
    stage_fifo_count_ff <= FIFO_PULL_LIMIT)
    else $error("Staging FIFO count passed the pull limit.");

  chk_stall_hold: assert property ( // RULE19
    out_valid_ff && !i_dma_out_ready |-> !stage_fifo_read_ack ##1 out_valid_ff && $stable(out_data_ff))
    else $error("Stream data changed while stalled.");

  chk_area_free: assert property ( // RULE4
    state_ff == state_begin_loop |-> !area_filled_ff[area_selector_ff])
    else $error("Loop began on a filled area.");

  chk_area_filled: assert property ( // RULE18
    loop_end && area_last_loop_ff |=> area_filled_ff[$past(area_selector_ff)]
      && area_selector_ff != $past(area_selector_ff))
    else $error("Area end did not set filled and toggle.");

  chk_release_clear: assert property ( // RULE3
    i_rx_area_release[0] && !area_set[0] |=> !area_filled_ff[0])
    else $error("Release did not clear area 0.");

  chk_done_idle: assert property ( // RULE15
    state_ff == state_check_ready && remaining_total_cnt_ff == SIZE_ZERO |=> !busy_ff && state_ff == state_idle)
    else $error("Busy did not drop at completion.");

  chk_burst_load: assert property ( // RULE21
    state_ff == state_check_ready && !final_loop |=> burst_remaining_ff == PKT_WORDS_B)
    else $error("Burst counter not loaded with a full packet.");

  chk_last_drop: assert property ( // RULE20
    loop_end |=> !out_valid_ff && !out_last_ff)
    else $error("Valid or last held after the final beat.");

  cov_full_loop: cover property (state_ff == state_move_data && loop_end && !final_loop);
  cov_area_switch: cover property (loop_end && area_last_loop_ff);
  cov_stall: cover property (out_valid_ff && !i_dma_out_ready ##1 i_dma_out_ready);
  cov_finish: cover property (busy_ff ##1 !busy_ff);
endmodule : rsd_rx_stream_dma

// >>> rsd_pkg.sv
package rsd_pkg;
  // Widths of the data path and size fields.
  localparam int unsigned DATA_W = 512;
  localparam int unsigned SIZE_W = 32;
  localparam int unsigned CH_W = 8;
  localparam int unsigned BURST_W = 8;
  localparam int unsigned FIFO_AW = 9;
  localparam int unsigned FIFO_CW = 10;
  // Packet length in words and staging FIFO thresholds.
  localparam logic [SIZE_W-1:0] PKT_WORDS = 32'h0000_0080;
  localparam logic [BURST_W-1:0] PKT_WORDS_B = 8'h80;
  localparam logic [BURST_W-1:0] BURST_ONE = 8'h01;
  localparam logic [FIFO_CW-1:0] FIFO_PULL_LIMIT = 10'h1f8;
  localparam logic [FIFO_AW-1:0] PTR_ONE = 9'h001;
  localparam logic [FIFO_CW-1:0] CNT_ONE = 10'h001;
  localparam logic [SIZE_W-1:0] SIZE_ZERO = 32'h0000_0000;
  localparam logic [1:0] AREA_NONE = 2'h0;

  // Sequencer states.
  typedef enum logic [1:0] {
    state_idle = 2'b00,
    state_check_ready = 2'b01,
    state_begin_loop = 2'b10,
    state_move_data = 2'b11
  } rsd_state_t;

  // Transfer request from the requester.
  typedef struct packed {
    logic rx_xfer_start;
    logic [SIZE_W-1:0] rx_total_size;
    logic [SIZE_W-1:0] rx_area_size;
  } rsd_req_t;

  // Outgoing stream beat towards the DMA engine.
  typedef struct packed {
    logic [DATA_W-1:0] dma_out_data;
    logic dma_out_valid;
    logic dma_out_last;
  } rsd_axis_t;
endpackage : rsd_pkg

// >>> rsd_dma_sink.sv
`timescale 1ns/1ps
// Stream sink in place of the DMA engine, prompt or stalling.
module rsd_dma_sink (
  input wire logic i_ref_clk,
  input wire logic i_slow,
  output logic o_ready
);
  logic [2:0] cnt_ff = 3'h0;
  // Ready moves after the falling edge only, so it is settled at sampling.
  always @(negedge i_ref_clk) begin
    cnt_ff <= cnt_ff + 3'h1;
    o_ready <= !i_slow || (cnt_ff[0] ^ cnt_ff[2]);
  end
endmodule : rsd_dma_sink

// >>> rx_stream_to_dma_double_buffer_bench.sv
`timescale 1ns/1ps
module rx_stream_to_dma_double_buffer_bench;
  import rsd_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  rsd_req_t req = '0;
  logic [1:0] rel = 2'h0;
  logic empty = 1'b1;
  logic [DATA_W-1:0] edata = '0;
  logic slow = 1'b0, host = 1'b1, eslow = 1'b0, popped = 1'b0;
  logic busy, rd_en, ready, msel;
  logic [1:0] filled, setb;
  logic [1:0] mfil = 2'h0;
  rsd_axis_t strm;
  logic [CH_W-1:0] chan;
  logic [FIFO_CW-1:0] cnt;
  logic [31:0] rnd = 32'h7bf9a605;
  logic [DATA_W-1:0] q[$];
  logic [DATA_W-1:0] exp_w;
  int checked = 0, failures = 0;
  int tot = 0, asz = 0, arem = 0, blen = 0, idx = 0, mbusy = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  rsd_rx_stream_dma #(.P_DMA_CHANNEL(8'h08)) u_rsd_rx_stream_dma (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_req(req), .o_rx_xfer_busy(busy),
    .o_rx_area_filled(filled), .i_rx_area_release(rel), .i_engine_fifo_empty(empty),
    .i_engine_data(edata), .o_engine_rd_en(rd_en), .o_stream(strm), .i_dma_out_ready(ready),
    .o_dma_channel(chan), .o_stage_fifo_count(cnt));
  rsd_dma_sink u_rsd_dma_sink (.i_ref_clk(i_ref_clk), .i_slow(slow), .o_ready(ready));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_val

  task automatic cmp_data(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_data

  task automatic print_verdict();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // Reference model: queue of pulled words, packet and area bookkeeping.
  always @(posedge i_ref_clk) begin
    setb = 2'h0;
    if (i_srst) begin
      q.delete();
      mfil = 2'h0;
      popped = 1'b0;
    end else begin
      cmp_val(rd_en, !empty && cnt < FIFO_PULL_LIMIT);
      // Words pulled and not yet accepted, less the one held in the output register.
      cmp_val(cnt, q.size() - strm.dma_out_valid);
      popped = rd_en && !empty;
      if (popped) q.push_back(edata);
      if (strm.dma_out_valid && ready) begin
        exp_w = q.size() > 0 ? q.pop_front() : 'x;
        cmp_data(strm.dma_out_data, exp_w);
        cmp_val(strm.dma_out_last, idx == blen - 1);
        cmp_val(mfil[msel], 1'b0);
        idx++;
        arem--;
        tot--;
        if (idx == blen) begin
          idx = 0;
          blen = tot < 128 ? tot : 128;
        end
        if (arem == 0) begin
          setb[msel] = 1'b1;
          msel = ~msel;
          arem = asz;
        end
      end
      // A set in the same cycle as a release wins.
      mfil = (mfil & ~rel) | setb;
      if (req.rx_xfer_start && mbusy == 0) begin
        mbusy = 1;
        tot = int'(req.rx_total_size);
        asz = int'(req.rx_area_size);
        arem = asz;
        msel = 1'b0;
        idx = 0;
        blen = tot < 128 ? tot : 128;
      end
    end
  end

  // Engine source and host: new word after each pop, releases of filled areas.
  always @(negedge i_ref_clk) begin
    rnd = lfsr(rnd);
    if (popped || empty) edata = {16{rnd}};
    empty = eslow & rnd[3];
    rel = host ? (mfil & rnd[5:4]) : 2'h0;
    cmp_val(filled, mfil);
  end

  // One request; a stray start is pulsed while busy at cycle stray.
  task automatic run_req(input int t, input int a, input int stray);
    int n;
    @(negedge i_ref_clk);
    req = '{1'b1, 32'(t), 32'(a)};
    @(negedge i_ref_clk);
    req.rx_xfer_start = 1'b0;
    cmp_val(busy, 1'b1);
    for (n = 0; n < 20000 && busy === 1'b1; n++) begin
      req.rx_xfer_start = (n == stray);
      @(negedge i_ref_clk);
    end
    req.rx_xfer_start = 1'b0;
    mbusy = 0;
    cmp_val(busy, 1'b0);
    cmp_val(tot, 0);
    cmp_val(idx, 0);
  endtask : run_req

  // Main sequence.
  initial begin
    repeat (20) @(negedge i_ref_clk);
    i_srst = 1'b0;
    cmp_val({busy, filled, strm.dma_out_valid, strm.dma_out_last}, 5'h00);
    cmp_val(cnt, 10'h000);
    cmp_val(chan, 8'h08);
    slow = 1'b1;
    run_req(260, 256, 30);
    host = 1'b0;
    fork
      run_req(512, 128, -1);
      begin
        repeat (1500) @(negedge i_ref_clk);
        cmp_val(cnt, FIFO_PULL_LIMIT);
        host = 1'b1;
      end
    join
    // Reset between requests, with words left in the staging FIFO and areas possibly filled.
    i_srst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    i_srst = 1'b0;
    cmp_val({busy, filled, strm.dma_out_valid, strm.dma_out_last}, 5'h00);
    cmp_val(cnt, 10'h000);
    slow = 1'b0;
    eslow = 1'b1;
    run_req(300, 128, -1);
    run_req(0, 128, -1);
    print_verdict();
  end

  // Watchdog: the run needs well under 50000 cycles.
  initial begin
    #500000;
    failures++;
    print_verdict();
  end
endmodule : rx_stream_to_dma_double_buffer_bench
